// *** xie_execute.v ***
// Decode and execute of the literal and file exclusive-OR instructions.
// Assumes the fetch stage holds an opcode with a valid strobe for one cycle
// and that the file register operand is read one cycle ahead by the core.
`include "xie_regs.vh"
//
// Timing of one instruction:
// Edge one takes the opcode. It needs opc_ready high (idle), opc_valid high and a pattern match.
// At that edge the opcode word, its class and the carry flags are captured.
// The file register is read at that same edge, so the operand stands in the execute cycle.
// Edge two writes the result into the accumulator or the file byte, and the zero flag.
// The cycle after edge two shows done_ff high for one cycle.
// Capture and execute together make one instruction cycle of the core.
//
// Hazards and limits:
// The file byte is read and written through one small memory with one read port.
// A new opcode is refused while busy, so a write never meets a read of a stale byte.
// The cost is that at most one instruction is taken every two clocks.
// A write and a read of the same byte in one cycle return the old byte.
// Preload writes are only taken while idle, for the same reason.
// The memory is not reset, so software must write a byte before reading it.
// A valid opcode that is not one of the two XOR forms is dropped.
// It raises illegal_ff for one cycle; it still loads opc_ff and the two class flags, but changes no other state.
//
// Flags:
// The zero flag follows every XOR result, whichever destination the result takes.
// The carry and digit-carry flags only mirror the core's inputs while idle.
// The XOR never writes them, so an instruction cannot disturb them.
//
// Reset:
// The reset pin clears the block at once, but its release passes two flip-flops.
// This keeps the release from landing close to a clock edge in some registers only.
// The first opcode can then be taken at the third edge after the pin goes high.
//
module xie_execute (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        opc_valid,
    input  wire [13:0] opc_word,
    input  wire        carry_in,
    input  wire        dcarry_in,
    input  wire        preload_en,
    input  wire [6:0]  preload_addr,
    input  wire [7:0]  preload_data,
    input  wire [6:0]  peek_addr,
    output wire [7:0]  peek_data,
    output wire        opc_ready,
    output reg  [7:0]  acc_ff,
    output reg         zero_ff,
    output reg         carry_ff,
    output reg         dcarry_ff,
    output reg         done_ff,
    output reg         illegal_ff
);
    // Two states are enough: capture in idle, then one execute cycle.
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    // Reset release pipeline and the internal reset it drives.
    reg [1:0]  rst_pipe_ff;
    wire       rst_n_int;

    // Control state, captured opcode and its class.
    reg        state_ff;
    reg        nxt_state;
    reg [13:0] opc_ff;
    reg        lit_hit_ff;
    reg        file_hit_ff;
    // Next values of the accumulator and zero flag, and the file write strobe.
    reg [7:0]  nxt_acc;
    reg        nxt_zero;
    reg        file_wr;
    reg [7:0]  result;
    // Operand read from the file, and the two decode hits of the live opcode.
    wire [7:0] file_data;
    wire       lit_hit;
    wire       file_hit;

    // Pattern match shared by both decode points.
    function match;
        input [13:0] word;
        input [13:0] mask;
        input [13:0] pattern;
        begin
            match = ((word & mask) == pattern);
        end
    endfunction

    assign lit_hit  = match(opc_word, `XIE_LIT_MASK, `XIE_LIT_PATTERN);
    assign file_hit = match(opc_word, `XIE_FILE_MASK, `XIE_FILE_PATTERN);
    // Taking a new opcode only in idle keeps the file read and write from colliding.
    assign opc_ready = (state_ff == ST_IDLE);

    // The file is read at capture time so the operand is ready the next edge.
    xie_file_ram u_ram (
        .mclk       (mclk),
        .rd_addr    (opc_ready ? opc_word[6:0] : peek_addr),
        .rd_data_ff (file_data),
        .wr_en      (file_wr | (preload_en & opc_ready)),
        .wr_addr    (file_wr ? opc_ff[6:0] : preload_addr),
        .wr_data    (file_wr ? result : preload_data)
    );
    // While busy the read port serves the peek address, one cycle late.
    assign peek_data = file_data;

    // Reset asserts at once and is released two edges after the pin goes high.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_n_int = rst_pipe_ff[1];

    // Execute stage: form the result and choose where it lands.
    always @* begin
        nxt_state = state_ff;
        nxt_acc   = acc_ff;
        nxt_zero  = zero_ff;
        file_wr   = 1'b0;
        result    = 8'h00;
        case (state_ff)
            ST_IDLE: begin
                if (opc_valid && (lit_hit || file_hit)) begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nxt_state = ST_IDLE;
                if (lit_hit_ff) begin
                    result   = acc_ff ^ opc_ff[7:0];
                    nxt_acc  = result;
                    nxt_zero = (result == 8'h00);
                end else if (file_hit_ff) begin
                    result = acc_ff ^ file_data;
                    if (opc_ff[`XIE_DEST_BIT]) begin
                        file_wr = 1'b1;
                    end else begin
                        nxt_acc = result;
                    end
                    nxt_zero = (result == 8'h00);
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State, operands and flags; carry flags only follow the core, never the XOR.
    // Only constants are loaded in the reset branch.
    always @(posedge mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_ff    <= ST_IDLE;
            opc_ff      <= 14'h0000;
            lit_hit_ff  <= 1'b0;
            file_hit_ff <= 1'b0;
            acc_ff      <= `XIE_ACC_RESET;
            zero_ff     <= `XIE_ZERO_RESET;
            carry_ff    <= 1'b0;
            dcarry_ff   <= 1'b0;
            done_ff     <= 1'b0;
            illegal_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            acc_ff    <= nxt_acc;
            zero_ff   <= nxt_zero;
            done_ff   <= (state_ff == ST_EXEC);
            if (opc_ready) begin
                carry_ff  <= carry_in;
                dcarry_ff <= dcarry_in;
            end
            illegal_ff <= opc_ready & opc_valid & ~(lit_hit | file_hit);
            if (opc_ready && opc_valid) begin
                opc_ff      <= opc_word;
                lit_hit_ff  <= lit_hit;
                file_hit_ff <= file_hit;
            end
        end
    end
endmodule

// *** xie_regs.vh ***
// Constants for the exclusive-OR execute block: opcode patterns, fields, resets.
// Assumes a 14-bit opcode word and an 8-bit data path on a 25 MHz core clock.
`ifndef XIE_REGS_VH
`define XIE_REGS_VH
`define XIE_OPC_W        14
`define XIE_DATA_W       8
`define XIE_ADDR_W       7
`define XIE_LIT_MASK     14'h3f00
`define XIE_LIT_PATTERN  14'h3a00
`define XIE_FILE_MASK    14'h3f00
`define XIE_FILE_PATTERN 14'h0600
`define XIE_DEST_BIT     7
`define XIE_ACC_RESET    8'h00
`define XIE_ZERO_RESET   1'h0
`define XIE_FILE_DEPTH   128
`define XIE_CYCLES       1
`endif

// *** xie_file_ram.v ***
// Small data register file of 128 bytes for the exclusive-OR execute block.
// Assumes one read address and one write port on the same core clock.
`include "xie_regs.vh"
module xie_file_ram (
    input  wire        mclk,
    input  wire [6:0]  rd_addr,
    output reg  [7:0]  rd_data_ff,
    input  wire        wr_en,
    input  wire [6:0]  wr_addr,
    input  wire [7:0]  wr_data
);
    reg [7:0] mem [0:`XIE_FILE_DEPTH-1];

    // Registered read so the data leave from a flip-flop; write takes one edge.
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule

// *** xie_checker.sv ***
// Checker for the exclusive-OR execute block.
// Sees only the block's ports; carry_in is held steady by the bench.
module xie_checker (
    input wire        mclk,
    input wire        arst_n,
    input wire        opc_valid,
    input wire [13:0] opc_word,
    input wire        opc_ready,
    input wire [7:0]  acc_ff,
    input wire        zero_ff,
    input wire        carry_ff,
    input wire        carry_in,
    input wire        done_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Take condition and the two opcode classes.
    wire tk  = opc_ready && opc_valid;
    wire lit = opc_word[13:8] == 6'h3a;
    wire fil = opc_word[13:8] == 6'h06;
    a_lit_value: assert property (tk && lit |-> ##2 acc_ff == ($past(acc_ff, 2) ^ $past(opc_word[7:0], 2)))
        else $error("literal result wrong");
    a_lit_zero: assert property (tk && lit |-> ##2 zero_ff == (acc_ff == 8'h00))
        else $error("literal zero flag wrong");
    a_busy_once: assert property (tk && (lit || fil) |=> !opc_ready ##1 (opc_ready && done_ff))
        else $error("busy span wrong");
    a_file_zero: assert property (tk && fil && !opc_word[7] |-> ##2 zero_ff == (acc_ff == 8'h00))
        else $error("file zero flag wrong");
    a_dest_keep: assert property (tk && fil && opc_word[7] |-> ##2 acc_ff == $past(acc_ff, 2))
        else $error("accumulator changed");
    a_carry_kept: assert property (tk && (lit || fil) |-> ##2 carry_ff == $past(carry_in, 2))
        else $error("carry changed");
    c_lit: cover property (tk && lit);
    c_dst0: cover property (tk && fil && !opc_word[7]);
    c_dst1: cover property (tk && fil && opc_word[7]);
endmodule

// *** xie_fetch_model.sv ***
// Fetch stage model: presents one opcode until it is taken.
// Assumes req is a one-cycle pulse given only while the block is idle.
module xie_fetch_model (
    input  wire        mclk,
    input  wire        req,
    input  wire [13:0] w,
    input  wire        opc_ready,
    output logic       opc_valid,
    output logic [13:0] opc_word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial opc_valid = 1'b0;
    initial opc_word = 14'h0000;
    // A released word is inverted so a stale opcode is never mistaken for a live one.
    always @(posedge mclk) begin
        if (req) begin
            opc_valid <= 1'b1;
            opc_word <= w;
        end else if (opc_ready && opc_valid) begin
            opc_valid <= 1'b0;
            opc_word <= ~opc_word;
        end
    end
endmodule

// *** xor_instruction_execute_tb.sv ***
// Bench for the exclusive-OR execute block with a fetch model in front.
// Assumes a 25 MHz clock and the file byte at address 5 preloaded.
module xor_instruction_execute_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, arst_n = 0, req = 0, pen = 0, rdy, vld, zf, cf, dn;
    logic [13:0] w = 0, ow;
    logic [7:0] acc, pk;
    logic il, dcf;
    int error_cnt = 0, check_count = 0;
    always #20 mclk = ~mclk;
    xie_fetch_model xie_fetch_model_i (.mclk(mclk), .req(req), .w(w), .opc_ready(rdy), .opc_valid(vld), .opc_word(ow));
    xie_execute xie_execute_i (.mclk(mclk), .arst_n(arst_n), .opc_valid(vld), .opc_word(ow), .carry_in(1'b1),
        .dcarry_in(1'b0), .preload_en(pen), .preload_addr(7'h05), .preload_data(8'haf), .peek_addr(7'h05),
        .peek_data(pk), .opc_ready(rdy), .acc_ff(acc), .zero_ff(zf), .carry_ff(cf), .dcarry_ff(dcf),
        .done_ff(dn), .illegal_ff(il));
    task ck(string n, logic [7:0] s, logic [7:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // Issue one opcode and wait a bounded time for its completion pulse.
    task ex(logic [13:0] v);
        @(posedge mclk) #1 req = 1;
        w = v;
        @(posedge mclk) #1 req = 0;
        for (int n = 0; n < 9 && dn !== 1'b1; n++) @(posedge mclk) #1;
        ck("done", dn, 8'h01);
    endtask
    task t_lit();
        ex(14'h3ab5);
        ck("acc", acc, 8'hb5);
        ex(14'h3aaf);
        ck("acc", acc, 8'h1a);
        ck("z", zf, 8'h00);
        ex(14'h3a1a);
        ck("z", zf, 8'h01);
        ex(14'h3aff);
        ck("acc", acc, 8'hff);
        ck("c", cf, 8'h01);
        ck("dc", dcf, 8'h00);
        $display("t_lit done");
    endtask
    task t_file();
        ex(14'h0685);
        ck("acc", acc, 8'hff);
        ex(14'h0605);
        ck("acc", acc, 8'haf);
        ck("file", pk, 8'h50);
        ex(14'h0605);
        ck("acc", acc, 8'hff);
        ck("file", pk, 8'h50);
        $display("t_file done");
    endtask
    // A non-XOR opcode must leave the accumulator alone and pulse the illegal flag.
    task t_ill();
        @(posedge mclk) #1 req = 1;
        w = 14'h0705;
        @(posedge mclk) #1 req = 0;
        @(posedge mclk) #1;
        ck("ill", il, 8'h01);
        ck("acc", acc, 8'hff);
        $display("t_ill done");
    endtask
    task stop_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset, preload the file byte, then run the scenarios.
    initial begin
        repeat (20) @(posedge mclk);
        #1 arst_n = 1;
        pen = 1;
        @(posedge mclk) #1 pen = 0;
        t_lit();
        t_file();
        t_ill();
        stop_test();
    end
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #100000 error_cnt++;
        stop_test();
    end
endmodule
bind xie_execute xie_checker xie_checker_i (.mclk(mclk), .arst_n(arst_n), .opc_valid(opc_valid),
    .opc_word(opc_word), .opc_ready(opc_ready), .acc_ff(acc_ff), .zero_ff(zero_ff), .carry_ff(carry_ff),
    .carry_in(carry_in), .done_ff(done_ff));
